// *** design/spfc_pkg.sv ***
// constants shared by the self-program flash control block
package spfc_pkg;
   // register byte offsets
   localparam logic [7:0] SPFC_OFF_CTRL = 8'h00;
   localparam logic [7:0] SPFC_OFF_STATUS = 8'h04;
   localparam logic [7:0] SPFC_OFF_MASK = 8'h08;
   localparam logic [7:0] SPFC_OFF_INFO = 8'h0C;
   // control register bit positions
   localparam int SPFC_B_IE = 7;
   localparam int SPFC_B_BUSY = 6;
   localparam int SPFC_B_RSV = 5;
   localparam int SPFC_B_RSRE = 4;
   localparam int SPFC_B_BLB = 3;
   localparam int SPFC_B_WRT = 2;
   localparam int SPFC_B_ERS = 1;
   localparam int SPFC_B_EN = 0;
   // status and mask bit positions
   localparam int SPFC_S_DONE = 0;
   localparam int SPFC_S_TMO = 1;
   // info register bit positions
   localparam int SPFC_I_FUSE = 0;
   localparam int SPFC_I_OPBUSY = 1;
   localparam int SPFC_I_BUFLD = 2;
   // reset values
   localparam logic [7:0] SPFC_CTRL_RST = 8'h00;
   localparam logic [1:0] SPFC_STATUS_RST = 2'h0;
   localparam logic [1:0] SPFC_MASK_RST = 2'h0;
   localparam logic SPFC_FUSE_RST = 1'b1;
   // windows in clock cycles
   localparam logic [2:0] SPFC_ARM_CYCLES = 3'h4;
   localparam logic [1:0] SPFC_LPM_CYCLES = 2'h3;
endpackage

// *** design/spfc_self_program_flash_control.sv ***
// self-program flash control: control register, arming windows, busy tracking, AHB-Lite slave
//
// Operation
// - ready interrupt requested while irq enable and global flag set and enable clear.
// - erase or write into read-while-write section sets the section busy flag.
// - section busy flag blocks every access to the read-while-write section.
// - re-enable write after completed programming clears the section busy flag.
// - starting a page buffer load clears the section busy flag.
// - unused control bit always reads as zero.
// - completion of page erase or page write clears the enable bit.
// - re-enable with enable, then store instruction within four cycles, re-enables section.
// - re-enable refused while erase or write in progress with enable set.
// - re-enable written during buffer load aborts the load and discards data.
// - boot lock set with enable, store within four cycles, writes low data to lock bits.
// - boot lock write ignores high data and the code address pointer.
// - boot lock set bit clears on lock write finish or four cycles without store.
// - load instruction within three cycles returns lock or fuse bits by pointer bit zero.
// - reset vector fuse unprogrammed selects address zero, programmed selects boot loader.
module spfc_self_program_flash_control
   import spfc_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter logic [15:0] RWW_LIMIT = 16'h1C00,
   parameter logic [15:0] BOOT_RESET_ADDR = 16'h1C00
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic global_irq_flag,
   input wire logic store_program_instruction,
   input wire logic load_program_instruction,
   input wire logic [ADDR_W-1:0] code_pointer,
   input wire logic [7:0] low_data_register,
   input wire logic [7:0] high_data_register,
   input wire logic flash_op_done,
   input wire logic [7:0] lock_bits,
   input wire logic [7:0] fuse_bits,
   input wire logic reset_vector_fuse,
   output logic flash_erase_start,
   output logic flash_write_start,
   output logic page_buffer_load,
   output logic page_buffer_discard,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [15:0] page_buffer_data,
   output logic lock_write,
   output logic [7:0] lock_write_data,
   output logic lpm_valid,
   output logic [7:0] lpm_data,
   output logic rww_access_block,
   output logic [15:0] reset_vector_addr,
   output logic prog_ready_irq,
   output logic irq
);

   typedef struct packed {
      logic ie;
      logic rsre;
      logic blb;
      logic wrt;
      logic ers;
      logic en;
      logic section_busy;
      logic op_busy;
      logic buf_loaded;
      logic [2:0] arm_cnt;
      logic [1:0] lpm_cnt;
      logic [1:0] status;
      logic [1:0] mask;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic fuse_s1;
      logic fuse_s2;
      logic fuse_s3;
      logic fuse_q;
      logic [15:0] rst_vec;
      logic erase_start;
      logic write_start;
      logic load_strobe;
      logic discard;
      logic [ADDR_W-1:0] op_addr;
      logic [15:0] load_data;
      logic lock_wr;
      logic [7:0] lock_data;
      logic lpm_vld;
      logic [7:0] lpm_q;
   } spfc_state_s;

   spfc_state_s st;
   spfc_state_s next_st;

   logic addr_phase;
   logic spm_accept;
   logic in_rww;
   logic ctrl_wr;
   logic [7:0] wd;
   logic [1:0] events;
   logic [1:0] w1c;

   assign addr_phase = hsel && htrans[1] && hready;
   // a store counts only inside the arming window and while no page operation runs
   assign spm_accept = store_program_instruction && st.en && (st.arm_cnt != 3'h0) && !st.op_busy;
   // pointers below the limit fall in the read-while-write section
   assign in_rww = ({{(32-ADDR_W){1'b0}}, code_pointer} < {16'h0000, RWW_LIMIT});
   assign ctrl_wr = st.dp_valid && st.dp_write && (st.dp_addr == SPFC_OFF_CTRL);
   assign wd = hwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      events = 2'h0;
      w1c = 2'h0;
      next_st.erase_start = 1'b0;
      next_st.write_start = 1'b0;
      next_st.load_strobe = 1'b0;
      next_st.discard = 1'b0;
      next_st.lock_wr = 1'b0;
      next_st.lpm_vld = 1'b0;

      // fuse pin: a change counts once stages two and three agree
      next_st.fuse_s1 = reset_vector_fuse;
      next_st.fuse_s2 = st.fuse_s1;
      next_st.fuse_s3 = st.fuse_s2;
      if (st.fuse_s2 == st.fuse_s3) begin
         next_st.fuse_q = st.fuse_s3;
      end
      next_st.rst_vec = st.fuse_q ? 16'h0000 : BOOT_RESET_ADDR;

      // arming windows count down
      if (st.arm_cnt != 3'h0) begin
         next_st.arm_cnt = st.arm_cnt - 3'h1;
      end
      if (st.lpm_cnt != 2'h0) begin
         next_st.lpm_cnt = st.lpm_cnt - 2'h1;
      end

      if (load_program_instruction && st.lpm_cnt != 2'h0 && st.blb && st.en) begin
         next_st.lpm_vld = 1'b1;
         next_st.lpm_q = code_pointer[0] ? fuse_bits : lock_bits;
      end

      if (spm_accept) begin
         next_st.arm_cnt = 3'h0;
         next_st.lpm_cnt = 2'h0;
         if (st.ers || st.wrt) begin
            next_st.erase_start = st.ers;
            next_st.write_start = st.wrt && !st.ers;
            next_st.op_addr = code_pointer;
            next_st.op_busy = 1'b1;
            next_st.buf_loaded = 1'b0;
            if (in_rww) begin
               next_st.section_busy = 1'b1;
            end
         end else if (st.rsre) begin
            next_st.section_busy = 1'b0;
            next_st.rsre = 1'b0;
            next_st.en = 1'b0;
            events[SPFC_S_DONE] = 1'b1;
         end else if (st.blb) begin
            next_st.lock_wr = 1'b1;
            next_st.lock_data = low_data_register;
            next_st.blb = 1'b0;
            next_st.en = 1'b0;
            events[SPFC_S_DONE] = 1'b1;
         end else begin
            next_st.load_strobe = 1'b1;
            next_st.op_addr = code_pointer;
            next_st.load_data = {high_data_register, low_data_register};
            next_st.buf_loaded = 1'b1;
            next_st.section_busy = 1'b0;
            next_st.en = 1'b0;
         end
      end else if (st.en && !st.op_busy && st.arm_cnt == 3'h1) begin
         next_st.en = 1'b0;
         next_st.blb = 1'b0;
         next_st.rsre = 1'b0;
         next_st.wrt = 1'b0;
         next_st.ers = 1'b0;
         next_st.lpm_cnt = 2'h0;
         events[SPFC_S_TMO] = 1'b1;
      end

      if (st.op_busy && flash_op_done) begin
         next_st.op_busy = 1'b0;
         next_st.en = 1'b0;
         next_st.ers = 1'b0;
         next_st.wrt = 1'b0;
         events[SPFC_S_DONE] = 1'b1;
      end

      // data phase register writes
      if (ctrl_wr) begin
         next_st.ie = wd[SPFC_B_IE];
         if (!st.op_busy) begin
            next_st.rsre = wd[SPFC_B_RSRE];
            next_st.blb = wd[SPFC_B_BLB];
            next_st.wrt = wd[SPFC_B_WRT];
            next_st.ers = wd[SPFC_B_ERS];
            next_st.en = wd[SPFC_B_EN];
            next_st.arm_cnt = wd[SPFC_B_EN] ? SPFC_ARM_CYCLES : 3'h0;
            next_st.lpm_cnt = (wd[SPFC_B_EN] && wd[SPFC_B_BLB]) ? SPFC_LPM_CYCLES : 2'h0;
            if (wd[SPFC_B_RSRE] && st.buf_loaded) begin
               next_st.discard = 1'b1;
               next_st.buf_loaded = 1'b0;
            end
         end
      end else if (st.dp_valid && st.dp_write && st.dp_addr == SPFC_OFF_STATUS) begin
         w1c = hwdata[1:0];
      end else if (st.dp_valid && st.dp_write && st.dp_addr == SPFC_OFF_MASK) begin
         next_st.mask = hwdata[1:0];
      end
      // set wins over clear
      next_st.status = (st.status & ~w1c) | events;

      // address phase capture and read data from the updated state
      next_st.dp_valid = addr_phase;
      next_st.dp_write = hwrite;
      next_st.dp_addr = {haddr[7:2], 2'b00};
      next_st.rdata = st.rdata;
      if (addr_phase && !hwrite) begin
         if ({haddr[7:2], 2'b00} == SPFC_OFF_CTRL) begin
            next_st.rdata = {24'h000000, next_st.ie, next_st.section_busy, 1'b0, next_st.rsre,
                             next_st.blb, next_st.wrt, next_st.ers, next_st.en};
         end else if ({haddr[7:2], 2'b00} == SPFC_OFF_STATUS) begin
            next_st.rdata = {30'h00000000, next_st.status};
         end else if ({haddr[7:2], 2'b00} == SPFC_OFF_MASK) begin
            next_st.rdata = {30'h00000000, next_st.mask};
         end else if ({haddr[7:2], 2'b00} == SPFC_OFF_INFO) begin
            next_st.rdata = {29'h00000000, next_st.buf_loaded, next_st.op_busy, next_st.fuse_q};
         end else begin
            next_st.rdata = 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
         st.fuse_s1 <= SPFC_FUSE_RST;
         st.fuse_s2 <= SPFC_FUSE_RST;
         st.fuse_s3 <= SPFC_FUSE_RST;
         st.fuse_q <= SPFC_FUSE_RST;
         st.status <= SPFC_STATUS_RST;
         st.mask <= SPFC_MASK_RST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // zero-wait slave: every transfer completes in one data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
   assign flash_erase_start = st.erase_start;
   assign flash_write_start = st.write_start;
   assign page_buffer_load = st.load_strobe;
   assign page_buffer_discard = st.discard;
   assign flash_addr = st.op_addr;
   assign page_buffer_data = st.load_data;
   assign lock_write = st.lock_wr;
   assign lock_write_data = st.lock_data;
   assign lpm_valid = st.lpm_vld;
   assign lpm_data = st.lpm_q;
   assign rww_access_block = st.section_busy;
   assign reset_vector_addr = st.rst_vec;
   assign prog_ready_irq = st.ie && global_irq_flag && !st.en;
   // level interrupt while any unmasked sticky status bit is set
   assign irq = |(st.status & st.mask);

   ////////////////////////////////////////////////////////////////////////////
   // assertions on the sequencer outputs
   logic rd_ctrl;
   logic ptr_bit0;
   assign rd_ctrl = addr_phase && !hwrite && ({haddr[7:2], 2'b00} == SPFC_OFF_CTRL);
   assign ptr_bit0 = code_pointer[0];

   property p_ready_irq;
      @(posedge hclk) disable iff (!hresetn)
      ($fell(st.en) && st.ie && global_irq_flag) |-> prog_ready_irq;
   endproperty
   a_ready_irq: assert property (p_ready_irq) else $error("ready request missing");

   property p_busy_set;
      @(posedge hclk) disable iff (!hresetn)
      (spm_accept && (st.ers || st.wrt) && in_rww) |=> (rww_access_block && st.op_busy);
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("section busy not set");

   property p_busy_cause;
      @(posedge hclk) disable iff (!hresetn)
      $rose(rww_access_block) |-> (flash_erase_start || flash_write_start);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose without op");

   property p_load_clears;
      @(posedge hclk) disable iff (!hresetn)
      page_buffer_load |-> !rww_access_block;
   endproperty
   a_load_clears: assert property (p_load_clears) else $error("load left busy");

   property p_reserved;
      @(posedge hclk) disable iff (!hresetn)
      rd_ctrl |=> (hrdata[5] == 1'b0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit nonzero");

   property p_done_clears;
      @(posedge hclk) disable iff (!hresetn)
      (st.op_busy && flash_op_done && !ctrl_wr) |=> (!st.en && !st.op_busy);
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("enable kept after done");

   property p_refuse;
      @(posedge hclk) disable iff (!hresetn)
      (st.op_busy && !flash_op_done) |=> $stable(rww_access_block);
   endproperty
   a_refuse: assert property (p_refuse) else $error("busy changed while programming");

   property p_lock_data;
      @(posedge hclk) disable iff (!hresetn)
      lock_write |-> (lock_write_data == $past(low_data_register));
   endproperty
   a_lock_data: assert property (p_lock_data) else $error("lock data not low register");

   property p_window;
      @(posedge hclk) disable iff (!hresetn)
      (ctrl_wr && wd[0] && !st.op_busy) ##1 (!store_program_instruction [*4]) |=> !st.en;
   endproperty
   a_window: assert property (p_window) else $error("enable outlived window");

   property p_lpm;
      @(posedge hclk) disable iff (!hresetn)
      lpm_valid |-> (lpm_data == ($past(ptr_bit0) ? $past(fuse_bits) : $past(lock_bits)));
   endproperty
   a_lpm: assert property (p_lpm) else $error("wrong lock or fuse readback");

   property p_vector;
      @(posedge hclk) disable iff (!hresetn)
      (st.fuse_q ##1 st.fuse_q) |-> (reset_vector_addr == 16'h0000);
   endproperty
   a_vector: assert property (p_vector) else $error("vector not zero");

endmodule

// *** bench/spfc_core_model.sv ***
// core and flash macro stand-in driving store and load strobes for the self-program control block
module spfc_core_model (
   input wire logic hclk,
   input wire logic flash_erase_start,
   input wire logic flash_write_start,
   output logic store_program_instruction,
   output logic load_program_instruction,
   output logic [15:0] code_pointer,
   output logic [7:0] low_data_register,
   output logic [7:0] high_data_register,
   output logic flash_op_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int done_delay = 2;
   int cnt = 0;
   bit drv = 0;
   initial begin
      store_program_instruction = 1'b0;
      load_program_instruction = 1'b0;
      code_pointer = 16'h0000;
      low_data_register = 8'h00;
      high_data_register = 8'h00;
      flash_op_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // unqualified data lines change every cycle
   always @(posedge hclk) begin
      if (!drv) begin
         code_pointer <= 16'($urandom());
         low_data_register <= 8'($urandom());
         high_data_register <= 8'($urandom());
      end
   end
   // flash macro reports completion after done_delay cycles
   always @(posedge hclk) begin
      flash_op_done <= 1'b0;
      if (flash_erase_start === 1'b1 || flash_write_start === 1'b1) begin
         cnt <= done_delay;
      end else if (cnt == 1) begin
         cnt <= 0;
         flash_op_done <= 1'b1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // strobe in window
   task automatic strobe(input bit is_store, input logic [15:0] p, input logic [7:0] lo, input logic [7:0] hi);
      drv = 1;
      code_pointer <= p;
      low_data_register <= lo;
      high_data_register <= hi;
      if (is_store) store_program_instruction <= 1'b1;
      else load_program_instruction <= 1'b1;
      @(posedge hclk);
      store_program_instruction <= 1'b0;
      load_program_instruction <= 1'b0;
      drv = 0;
   endtask
endmodule

// *** bench/tb_self_program_flash_control.sv ***
// self-checking testbench for the self-program flash control block
module tb_self_program_flash_control import spfc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, gif, fuse;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic store, load, op_done, ers, wrs, ld, disc, lkw, lpm_v, block, pri, irq;
   logic [15:0] ptr, faddr, pbd, rva;
   logic [7:0] lo, hi, lock_bits, fuse_bits, lwd, lpmd;
   logic [15:0] p;
   logic [7:0] dl, dh;
   int n_errors = 0;
   int num_checks = 0;
   int c[6] = '{default: 0};
   int m[6] = '{default: 0};
   spfc_self_program_flash_control i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .global_irq_flag(gif),
      .store_program_instruction(store), .load_program_instruction(load), .code_pointer(ptr),
      .low_data_register(lo), .high_data_register(hi), .flash_op_done(op_done), .lock_bits(lock_bits),
      .fuse_bits(fuse_bits), .reset_vector_fuse(fuse), .flash_erase_start(ers), .flash_write_start(wrs),
      .page_buffer_load(ld), .page_buffer_discard(disc), .flash_addr(faddr), .page_buffer_data(pbd),
      .lock_write(lkw), .lock_write_data(lwd), .lpm_valid(lpm_v), .lpm_data(lpmd),
      .rww_access_block(block), .reset_vector_addr(rva), .prog_ready_irq(pri), .irq(irq));
   spfc_core_model i_core (.hclk(hclk), .flash_erase_start(ers), .flash_write_start(wrs),
      .store_program_instruction(store), .load_program_instruction(load), .code_pointer(ptr),
      .low_data_register(lo), .high_data_register(hi), .flash_op_done(op_done));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // pulses counted away from the launching edge
   always @(negedge hclk) begin
      c[0] += int'(ers === 1'b1);
      c[1] += int'(wrs === 1'b1);
      c[2] += int'(ld === 1'b1);
      c[3] += int'(lkw === 1'b1);
      c[4] += int'(disc === 1'b1);
      c[5] += int'(lpm_v === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp, input string nm);
      ahb(1'b0, a, 32'h00000000);
      chk(nm, rdv & msk, exp);
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge hclk);
   endtask
   task automatic rand_data;
      dl = 8'($urandom());
      dh = 8'($urandom());
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      final_report();
   end
   initial begin
      {hsel, hwrite, gif} = 3'h0;
      fuse = 1'b1;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'b00;
      hsize = 3'b010;
      lock_bits = 8'h00;
      fuse_bits = 8'h00;
      hresetn = 1'b0;
      void'($urandom(12));
      cyc(16);
      hresetn <= 1'b1;
      cyc(1);
      rc(SPFC_OFF_CTRL, 32'hFFFFFFFF, {24'h0, SPFC_CTRL_RST}, "ctrl_rst");
      rc(SPFC_OFF_STATUS, 32'hFFFFFFFF, 32'h00000000, "status_rst");
      rc(SPFC_OFF_MASK, 32'hFFFFFFFF, 32'h00000000, "mask_rst");
      rc(SPFC_OFF_INFO, 32'hFFFFFFFF, 32'h00000001, "info_rst");
      rc(8'h10, 32'hFFFFFFFF, 32'h00000000, "unmapped");
      wr(SPFC_OFF_CTRL, 32'h000000A0);
      rc(SPFC_OFF_CTRL, 32'hFFFFFFFF, 32'h00000080, "ctrl_rsv");
      for (int i = 0; i < 4; i++) begin
         gif <= 1'($urandom());
         cyc(1);
         chk("ready_irq", {31'h0, pri}, {31'h0, gif});
      end
      gif <= 1'b1;
      wr(SPFC_OFF_MASK, 32'h00000003);
      i_core.done_delay = 20;
      wr(SPFC_OFF_CTRL, 32'h00000083);
      i_core.strobe(1'b1, 16'($urandom() % 32'h1C00), 8'h00, 8'h00);
      m[0]++;
      cyc(3);
      chk("block", {31'h0, block}, 32'h1);
      chk("ready_irq_busy", {31'h0, pri}, 32'h0);
      rc(SPFC_OFF_CTRL, 32'h41, 32'h41, "busy_set");
      wr(SPFC_OFF_CTRL, 32'h00000091);
      rc(SPFC_OFF_CTRL, 32'h50, 32'h40, "reenable_refused");
      wait_irq();
      chk("irq_done", {31'h0, irq}, 32'h1);
      rc(SPFC_OFF_CTRL, 32'h41, 32'h40, "enable_clear");
      rc(SPFC_OFF_STATUS, 32'h3, 32'h1, "status_done");
      wr(SPFC_OFF_STATUS, 32'h00000001);
      rc(SPFC_OFF_STATUS, 32'h3, 32'h0, "status_w1c");
      chk("irq_clear", {31'h0, irq}, 32'h0);
      wr(SPFC_OFF_CTRL, 32'h00000091);
      i_core.strobe(1'b1, 16'($urandom()), 8'h00, 8'h00);
      cyc(2);
      chk("block_reenable", {31'h0, block}, 32'h0);
      rc(SPFC_OFF_CTRL, 32'h40, 32'h0, "busy_clear");
      // drop the re-enable done event so the next wait sees the erase finish
      wr(SPFC_OFF_STATUS, 32'h00000003);
      i_core.done_delay = 2;
      wr(SPFC_OFF_CTRL, 32'h00000083);
      i_core.strobe(1'b1, 16'($urandom() % 32'h1C00), 8'h00, 8'h00);
      m[0]++;
      wait_irq();
      wr(SPFC_OFF_STATUS, 32'h00000003);
      chk("block_again", {31'h0, block}, 32'h1);
      rand_data();
      wr(SPFC_OFF_CTRL, 32'h00000081);
      i_core.strobe(1'b1, 16'($urandom()), dl, dh);
      m[2]++;
      cyc(2);
      chk("block_load", {31'h0, block}, 32'h0);
      chk("page_data", {16'h0, pbd}, {16'h0, dh, dl});
      wr(SPFC_OFF_CTRL, 32'h00000091);
      m[4]++;
      cyc(8);
      rc(SPFC_OFF_STATUS, 32'h2, 32'h2, "timeout_flag");
      rc(SPFC_OFF_CTRL, 32'hFF, 32'h80, "disarm");
      chk("irq_tmo", {31'h0, irq}, 32'h1);
      wr(SPFC_OFF_MASK, 32'h00000001);
      cyc(1);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(SPFC_OFF_STATUS, 32'h00000003);
      wr(SPFC_OFF_MASK, 32'h00000003);
      wr(SPFC_OFF_CTRL, 32'h00000085);
      i_core.strobe(1'b1, 16'h1C00 + 16'($urandom() % 32'h400), 8'h00, 8'h00);
      m[1]++;
      cyc(3);
      chk("block_boot_sect", {31'h0, block}, 32'h0);
      wait_irq();
      wr(SPFC_OFF_STATUS, 32'h00000003);
      // erase and write armed together: only the erase starts
      wr(SPFC_OFF_CTRL, 32'h00000087);
      i_core.strobe(1'b1, 16'h1C00, 8'h00, 8'h00);
      m[0]++;
      wait_irq();
      chk("flash_addr", {16'h0, faddr}, 32'h00001C00);
      chk("block_erase_boot", {31'h0, block}, 32'h0);
      wr(SPFC_OFF_STATUS, 32'h00000003);
      wr(SPFC_OFF_CTRL, 32'h00000089);
      cyc(8);
      rc(SPFC_OFF_CTRL, 32'hFF, 32'h80, "lock_timeout");
      rc(SPFC_OFF_STATUS, 32'h2, 32'h2, "lock_tmo_flag");
      wr(SPFC_OFF_STATUS, 32'h00000003);
      rand_data();
      wr(SPFC_OFF_CTRL, 32'h00000089);
      i_core.strobe(1'b1, 16'($urandom()), dl, dh);
      m[3]++;
      cyc(2);
      chk("lock_data", {24'h0, lwd}, {24'h0, dl});
      rc(SPFC_OFF_CTRL, 32'hFF, 32'h80, "lock_done");
      for (int i = 0; i < 2; i++) begin
         lock_bits <= 8'($urandom());
         fuse_bits <= 8'($urandom());
         wr(SPFC_OFF_STATUS, 32'h00000003);
         wr(SPFC_OFF_CTRL, 32'h00000089);
         p = {15'($urandom()), 1'(i)};
         i_core.strobe(1'b0, p, 8'h00, 8'h00);
         m[5]++;
         cyc(2);
         chk("lpm_data", {24'h0, lpmd}, {24'h0, (i == 1) ? fuse_bits : lock_bits});
         cyc(6);
      end
      for (int i = 0; i < 6; i++) chk("pulse_count", 32'(c[i]), 32'(m[i]));
      fuse <= 1'b0;
      cyc(8);
      chk("vector_boot", {16'h0, rva}, 32'h00001C00);
      fuse <= 1'b1;
      cyc(8);
      chk("vector_app", {16'h0, rva}, 32'h00000000);
      final_report();
   end
endmodule
